// *** include/eeprom_rd_cfg.svh ***
`ifndef EEPROM_RD_CFG_SVH
`define EEPROM_RD_CFG_SVH

// Array geometry: 4096 bytes behind a 12-bit address.
`define EE_ADDR_W 12
`define EE_DATA_W 8
`define EE_DEPTH 4096

// Address counter reset value and step.
`define ADDR_RST 12'h000
`define ADDR_STEP 12'h001

// Bit position counter; the ninth clock of a byte is the acknowledge.
`define BIT_CNT_W 4
`define FIRST_BIT 4'h1
`define LAST_BIT 4'h7
`define ACK_SLOT 4'h8

// Field positions in the device address byte.
`define RW_POS 0
`define CS_LSB 1
`define CS_MSB 3
`define TYPE_LSB 4
`define TYPE_MSB 7

// The upper word address byte carries only the top address bits.
`define HI_ADDR_MSB 3

// Byte sent when no fetched data is ready.
`define DATA_IDLE 8'hFF

// Cycles of mclk that the link engine is held idle after a STOP.
`define STOP_HOLD_CYC 2'h3

`endif

// *** include/eeprom_rd_pkg.sv ***
`include "eeprom_rd_cfg.svh"

package eeprom_rd_pkg;

    // Phases of the link-side serial engine.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DEV = 3'b001,
        ST_ADDR_HI = 3'b010,
        ST_ADDR_LO = 3'b011,
        ST_SKIP = 3'b100,
        ST_SEND = 3'b101,
        ST_WAIT = 3'b110
    } link_state_t;

    // Fill port of the byte array, on mclk.
    typedef struct packed {
        logic en;
        logic [`EE_ADDR_W-1:0] addr;
        logic [`EE_DATA_W-1:0] data;
    } fill_t;

    // Bus conditions seen on the oversampled pins, one-cycle pulses.
    typedef struct packed {
        logic start;
        logic stop;
    } bus_event_t;

endpackage

// *** logic/byte_store.sv ***
`include "eeprom_rd_cfg.svh"

module byte_store #(
    parameter int AW = `EE_ADDR_W,
    parameter int DW = `EE_DATA_W,
    parameter int DEPTH = `EE_DEPTH
) (
    // Clock.
    input wire logic clk,
    // Write side.
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    // Read side; the data come out of a register.
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);

    logic [DW-1:0] mem [DEPTH];

    // Write on request and read every cycle.
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule // byte_store

// *** logic/bus_watch.sv ***
module bus_watch (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Bus pins, asynchronous to mclk.
    input wire logic scl_pin,
    input wire logic sda_pin,
    // Detected bus conditions.
    output eeprom_rd_pkg::bus_event_t ev
);
    import eeprom_rd_pkg::*;

    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic sda_prev;
    logic start_seen;
    logic stop_seen;

    // Only the second stages and the delayed copy feed the detectors.
    assign start_seen = scl_sync[1] & sda_prev & ~sda_sync[1];
    assign stop_seen = scl_sync[1] & ~sda_prev & sda_sync[1];

    // Two-stage synchronisers and the registered event pulses.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            sda_prev <= 1'b1;
            ev <= '0;
        end else begin
            scl_sync <= {scl_sync[0], scl_pin};
            sda_sync <= {sda_sync[0], sda_pin};
            sda_prev <= sda_sync[1];
            ev.start <= start_seen;
            ev.stop <= stop_seen;
        end
    end

endmodule // bus_watch

// *** logic/serial_eeprom_read_engine.sv ***
// Summary of operation
// - Matching read address byte is acknowledged low on the ninth clock.
// - After that acknowledge one byte is sent and the counter steps by one.
// - Controller acknowledge on clock eighteen makes the next byte follow.
// - Each further controller acknowledge brings one more byte, endlessly.
// - The address counter wraps from the top location back to zero.
// - Both dummy-write address bytes are acknowledged; then a read follows.
// - A repeated START drops the pending write and keeps the loaded address.
// - Only type code plus chip-select match is answered; else stay quiet.
// - Word address comes as two bytes holding a 12-bit location.
// - Bits are sampled on rising SCL and driven after falling SCL.
// - STOP during a read releases the bus and returns to standby.

`include "eeprom_rd_cfg.svh"

module serial_eeprom_read_engine #(
    // Device-type code of the address byte; the value is arbitrary.
    parameter logic [3:0] DEV_TYPE = 4'h5
) (
    // System clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Serial clock from the bus controller; clocks the link logic.
    input wire logic scl_clk,
    // Open-drain data line.
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Chip-select straps.
    input wire logic chip_select_bit2,
    input wire logic chip_select_bit1,
    input wire logic chip_select_bit0,
    // Array fill port.
    input wire eeprom_rd_pkg::fill_t fill,
    // Status.
    output logic standby
);
    import eeprom_rd_pkg::*;

    // mclk side: resets of the link logic and bus conditions.
    bus_event_t bus_ev;
    logic hard_rst;
    logic soft_rst;
    logic [1:0] hold_cnt;
    logic [1:0] next_hold;
    logic next_standby;

    // mclk side: address counter and array read.
    logic [`EE_ADDR_W-1:0] addr;
    logic [`EE_ADDR_W-1:0] next_addr;
    logic [`EE_DATA_W-1:0] rd_word;
    logic [2:0] load_sync;
    logic [2:0] inc_sync;
    logic load_ev;
    logic inc_ev;
    logic serve;
    logic done_tog;

    // Link side: serial engine.
    link_state_t state;
    link_state_t next_state;
    logic [`BIT_CNT_W-1:0] bitcnt;
    logic [`BIT_CNT_W-1:0] next_bitcnt;
    logic [6:0] shreg;
    logic [`EE_DATA_W-1:0] byte_in;
    logic [`EE_DATA_W-1:0] rx_byte;
    logic [`EE_DATA_W-1:0] tx;
    logic [`EE_DATA_W-1:0] next_tx;
    logic [`EE_DATA_W-1:0] tx_src;
    logic ack_pend;
    logic ack_want;
    logic dev_match;
    logic slot_end;
    logic last_bit;
    logic sda_at_rise;
    logic rs_tog;
    logic rs_seen;
    logic restart_pend;
    logic restart_now;
    logic next_oe;

    // Link side: state kept across frames.
    logic [`HI_ADDR_MSB:0] addr_hi;
    logic [`EE_ADDR_W-1:0] addr_word;
    logic load_tog;
    logic inc_tog;
    logic next_load;
    logic next_inc;
    logic [1:0] done_sync;
    logic data_ok;
    logic [2:0] cs_s1;
    logic [2:0] cs_s2;

    // START and STOP are seen on the oversampled pins.
    bus_watch u_watch (
        .mclk(mclk),
        .rst(rst),
        .scl_pin(scl_clk),
        .sda_pin(sda_i),
        .ev(bus_ev)
    );

    // A STOP holds the link engine idle for a few cycles of mclk.
    assign next_hold = bus_ev.stop ? `STOP_HOLD_CYC :
                       (hold_cnt != 2'h0) ? hold_cnt - 2'h1 : 2'h0;
    assign next_standby = bus_ev.stop ? 1'b1 :
                          bus_ev.start ? 1'b0 : standby;

    // Reset distribution; SCL stands high while these change.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hard_rst <= 1'b1;
            soft_rst <= 1'b1;
            hold_cnt <= `STOP_HOLD_CYC;
            standby <= 1'b1;
            sda_o <= 1'b0;
        end else begin
            hard_rst <= 1'b0;
            hold_cnt <= next_hold;
            soft_rst <= (next_hold != 2'h0);
            standby <= next_standby;
            sda_o <= 1'b0;
        end
    end

    // Link events arrive as toggles; stage 0 feeds only stage 1.
    assign load_ev = load_sync[2] ^ load_sync[1];
    assign inc_ev = inc_sync[2] ^ inc_sync[1];
    assign next_addr = load_ev ? addr_word :
                       inc_ev ? addr + `ADDR_STEP : addr;

    // Address counter; it survives STOP so a later read resumes.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            load_sync <= 3'h0;
            inc_sync <= 3'h0;
            addr <= `ADDR_RST;
            serve <= 1'b0;
            done_tog <= 1'b0;
        end else begin
            load_sync <= {load_sync[1:0], load_tog};
            inc_sync <= {inc_sync[1:0], inc_tog};
            addr <= next_addr;
            serve <= load_ev ^ inc_ev;
            done_tog <= done_tog ^ serve;
        end
    end

    // The array; its read word follows the counter one cycle later.
    byte_store #(
        .AW(`EE_ADDR_W),
        .DW(`EE_DATA_W),
        .DEPTH(`EE_DEPTH)
    ) u_store (
        .clk(mclk),
        .we(fill.en),
        .waddr(fill.addr),
        .wdata(fill.data),
        .raddr(addr),
        .rdata(rd_word)
    );

    // A word from mclk is used only once its handshake has closed.
    assign data_ok = (done_sync[1] == (load_tog ^ inc_tog));
    assign tx_src = data_ok ? rd_word : `DATA_IDLE;

    // Byte assembly and slot decoding.
    assign byte_in = {shreg, sda_i};
    assign restart_pend = rs_tog ^ rs_seen;
    assign slot_end = (bitcnt == `ACK_SLOT) & ~restart_pend;
    assign last_bit = (bitcnt == `LAST_BIT) & ~restart_pend;
    assign dev_match =
        (byte_in[`TYPE_MSB:`TYPE_LSB] == DEV_TYPE) &
        (byte_in[`CS_MSB:`CS_LSB] == cs_s2);
    assign ack_want = ((state == ST_DEV) & dev_match) |
                      (state == ST_ADDR_HI) |
                      (state == ST_ADDR_LO);
    assign next_bitcnt = restart_pend ? `FIRST_BIT :
                         slot_end ? '0 : bitcnt + `FIRST_BIT;

    // A START is a fall of SDA while SCL was high; an idle engine
    // takes its first falling SCL edge as the START of the frame.
    assign restart_now = (state == ST_IDLE) | (sda_at_rise & ~sda_i);

    // What the engine does at the end of each acknowledge slot.
    always_comb begin
        next_state = state;
        next_tx = tx;
        next_load = load_tog;
        next_inc = inc_tog;
        if (restart_pend) begin
            next_state = ST_DEV;
        end else if (slot_end) begin
            case (state)
                ST_DEV: begin
                    if (!ack_pend) begin
                        next_state = ST_WAIT;
                    end else if (rx_byte[`RW_POS]) begin
                        next_state = ST_SEND;
                        next_tx = tx_src;
                        next_inc = ~inc_tog;
                    end else begin
                        next_state = ST_ADDR_HI;
                    end
                end
                ST_ADDR_HI: begin
                    next_state = ST_ADDR_LO;
                end
                ST_ADDR_LO: begin
                    next_state = ST_SKIP;
                    next_load = ~load_tog;
                end
                ST_SEND: begin
                    if (!sda_i) begin
                        next_tx = tx_src;
                        next_inc = ~inc_tog;
                    end else begin
                        next_state = ST_WAIT;
                    end
                end
                default: begin
                    next_state = state;
                end
            endcase
        end
    end

    // Drive decision for the next full period of SCL.
    always_comb begin
        next_oe = 1'b0;
        if (restart_now) begin
            next_oe = 1'b0;
        end else if ((state == ST_SEND) && (bitcnt <= `LAST_BIT)) begin
            next_oe = ~tx[~bitcnt[2:0]];
        end else if ((bitcnt == `ACK_SLOT) && ack_pend) begin
            next_oe = 1'b1;
        end
    end

    // Rising SCL: sample SDA and advance the engine.
    always_ff @(posedge scl_clk or posedge soft_rst) begin
        if (soft_rst) begin
            state <= ST_IDLE;
            bitcnt <= '0;
            shreg <= 7'h00;
            rx_byte <= '0;
            ack_pend <= 1'b0;
            sda_at_rise <= 1'b1;
            rs_seen <= 1'b0;
            tx <= `DATA_IDLE;
        end else begin
            sda_at_rise <= sda_i;
            rs_seen <= rs_tog;
            state <= next_state;
            bitcnt <= next_bitcnt;
            shreg <= restart_pend ? {6'h00, sda_i} : byte_in[6:0];
            rx_byte <= last_bit ? byte_in : rx_byte;
            ack_pend <= last_bit & ack_want;
            tx <= next_tx;
        end
    end

    // Rising SCL: handshake toggles, word address and straps.
    always_ff @(posedge scl_clk or posedge hard_rst) begin
        if (hard_rst) begin
            load_tog <= 1'b0;
            inc_tog <= 1'b0;
            done_sync <= 2'h0;
            cs_s1 <= 3'h0;
            cs_s2 <= 3'h0;
            addr_hi <= '0;
            addr_word <= `ADDR_RST;
        end else begin
            load_tog <= next_load;
            inc_tog <= next_inc;
            done_sync <= {done_sync[0], done_tog};
            cs_s1 <= {chip_select_bit2, chip_select_bit1,
                      chip_select_bit0};
            cs_s2 <= cs_s1;
            if (slot_end && (state == ST_ADDR_HI)) begin
                addr_hi <= rx_byte[`HI_ADDR_MSB:0];
            end
            if (slot_end && (state == ST_ADDR_LO)) begin
                addr_word <= {addr_hi, rx_byte};
            end
        end
    end

    // Falling SCL: change the SDA drive and note a START.
    always_ff @(negedge scl_clk or posedge soft_rst) begin
        if (soft_rst) begin
            sda_oe <= 1'b0;
            rs_tog <= 1'b0;
        end else begin
            sda_oe <= next_oe;
            if (restart_now && !restart_pend) begin
                rs_tog <= ~rs_tog;
            end
        end
    end

endmodule // serial_eeprom_read_engine

// *** verif/serial_eeprom_read_engine_monitor.sv ***
module serial_eeprom_read_engine_monitor (
    // System clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Bus side.
    input wire logic scl_clk,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    // Status.
    input wire logic standby
);
    timeunit 1ns;
    timeprecision 100ps;

    // All checks oversample the bus on the system clock.
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);

    // Bus conditions and the open-drain drive.
    start_wake_a: assert property ($fell(sda_i) && scl_clk
        |-> ##[1:12] !standby) else $error("start did not wake engine");
    stop_standby_a: assert property ($rose(sda_i) && scl_clk
        |-> ##[1:10] standby) else $error("stop did not idle engine");
    oe_change_low_a: assert property ($changed(sda_oe) |-> !scl_clk)
        else $error("data drive changed while clock high");
    oe_stable_high_a: assert property (scl_clk && $past(scl_clk)
        |-> $stable(sda_oe)) else $error("data drive moved in high phase");
    oe_hold_a: assert property ($rose(sda_oe) |-> sda_oe[*4])
        else $error("low drive shorter than a clock period");
    standby_quiet_a: assert property (standby |-> !sda_oe)
        else $error("line driven in standby");
    standby_rise_a: assert property ($rose(standby)
        |-> scl_clk && sda_i) else $error("standby without stop");
    drive_level_a: assert property (sda_o == 1'b0)
        else $error("open-drain level not low");
endmodule // serial_eeprom_read_engine_monitor

// *** verif/bus_controller_model.sv ***
module bus_controller_model (
    // Clock and low drive toward the bus.
    output logic scl_clk,
    output logic sda_oe,
    // Resolved data line.
    input wire logic sda_i
);
    timeunit 1ns;
    timeprecision 100ps;

    // Clock stands high and data is released between frames.
    initial begin
        scl_clk = 1'b1;
        sda_oe = 1'b0;
    end

    // One bit: data set while clock low, read in the high phase.
    task automatic bit_slot(input logic b, output logic r);
        sda_oe = !b;
        #12 scl_clk = 1'b1;
        #12 r = sda_i;
        #12 scl_clk = 1'b0;
        #12;
    endtask

    // Start or repeated start: data falls while the clock is high.
    task automatic start_cond();
        sda_oe = 1'b0;
        #12 scl_clk = 1'b1;
        #12 sda_oe = 1'b1;
        #12 scl_clk = 1'b0;
        #12;
    endtask

    // Stop, then bus free time before any new start.
    task automatic stop_cond();
        sda_oe = 1'b1;
        #12 scl_clk = 1'b1;
        #12 sda_oe = 1'b0;
        #84;
    endtask

    // Sends a byte MSB first and returns the target's acknowledge.
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(b[i], r);
        end
        bit_slot(1'b1, ack);
    endtask

    // Receives a byte, then acknowledges it only if more are wanted.
    task automatic get_byte(input logic more, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(1'b1, b[i]);
        end
        bit_slot(!more, r);
    endtask
endmodule // bus_controller_model

// *** verif/serial_eeprom_read_engine_test.sv ***
`define CHECK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin \
    n_errors++; $display("wrong value %s exp %0h got %0h", what, exp, got); \
    end end

module serial_eeprom_read_engine_test import eeprom_rd_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [3:0] TYPE_CODE = 4'h6; // Arbitrary value.
    localparam logic [2:0] STRAPS = 3'b101;
    logic [2:0] straps = STRAPS;
    logic mclk, rst, scl_clk, sda_i, sda_o, dev_oe, ctl_oe, standby;
    fill_t fill;
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;

    // Open-drain line with pull-up.
    assign sda_i = !(dev_oe || ctl_oe);

    serial_eeprom_read_engine #(.DEV_TYPE(TYPE_CODE))
        u_serial_eeprom_read_engine (
        .mclk(mclk), .rst(rst), .scl_clk(scl_clk), .sda_i(sda_i),
        .sda_o(sda_o), .sda_oe(dev_oe), .chip_select_bit2(straps[2]),
        .chip_select_bit1(straps[1]), .chip_select_bit0(straps[0]),
        .fill(fill), .standby(standby));
    bus_controller_model u_bus_controller_model (
        .scl_clk(scl_clk), .sda_oe(ctl_oe), .sda_i(sda_i));

    // System clock.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Cuts a hung run short.
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            complete_run();
        end
    end

    function automatic logic [7:0] pat(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], 4'hA};
    endfunction

    task automatic put_word(input logic [11:0] a);
        @(negedge mclk);
        fill <= '{en: 1'b1, addr: a, data: pat(a)};
        @(negedge mclk);
        fill.en <= 1'b0;
    endtask

    task automatic dev_byte(input logic [7:0] b, input logic exp);
        logic ack;
        u_bus_controller_model.put_byte(b, ack);
        `CHECK("address ack", exp, ack)
    endtask

    // Optional dummy write, then a run of n bytes checked one by one.
    task automatic read_run(input logic [11:0] a, input int n, input logic ld);
        logic [7:0] b;
        u_bus_controller_model.start_cond();
        if (ld) begin
            dev_byte({TYPE_CODE, STRAPS, 1'b0}, 1'b0);
            dev_byte({4'h0, a[11:8]}, 1'b0);
            dev_byte(a[7:0], 1'b0);
            u_bus_controller_model.start_cond();
        end
        dev_byte({TYPE_CODE, STRAPS, 1'b1}, 1'b0);
        for (int i = 0; i < n; i++) begin
            u_bus_controller_model.get_byte(i < n - 1, b);
            `CHECK("read data", pat(a + 12'(i)), b)
        end
        u_bus_controller_model.stop_cond();
        repeat (8) @(negedge mclk);
        `CHECK("standby", 1'b1, standby)
    endtask

    task automatic test_random();
        read_run(12'h123, 3, 1'b1);
        $display("random read done");
    endtask

    task automatic test_wrap();
        read_run(12'hFFE, 4, 1'b1);
        $display("wrap read done");
    endtask

    // Foreign type code and foreign straps draw no acknowledge.
    task automatic test_foreign();
        u_bus_controller_model.start_cond();
        dev_byte({~TYPE_CODE, STRAPS, 1'b1}, 1'b1);
        u_bus_controller_model.start_cond();
        dev_byte({TYPE_CODE, 3'b100, 1'b1}, 1'b1);
        u_bus_controller_model.stop_cond();
        repeat (8) @(negedge mclk);
        `CHECK("standby", 1'b1, standby)
        // Moved straps: the old address is refused, the new one answered.
        straps = 3'b100;
        u_bus_controller_model.start_cond();
        dev_byte({TYPE_CODE, STRAPS, 1'b1}, 1'b1);
        u_bus_controller_model.start_cond();
        dev_byte({TYPE_CODE, 3'b100, 1'b0}, 1'b0);
        u_bus_controller_model.stop_cond();
        repeat (8) @(negedge mclk);
        straps = STRAPS;
        $display("foreign address done");
    endtask

    // Write data after a word address is neither acked nor stored.
    task automatic test_refused();
        u_bus_controller_model.start_cond();
        dev_byte({TYPE_CODE, STRAPS, 1'b0}, 1'b0);
        dev_byte(8'h01, 1'b0);
        dev_byte(8'h24, 1'b0);
        dev_byte(8'h00, 1'b1);
        u_bus_controller_model.stop_cond();
        repeat (8) @(negedge mclk);
        read_run(12'h124, 1, 1'b0);
        $display("refused write done");
    endtask

    task automatic test_current();
        read_run(12'h002, 1, 1'b0);
        $display("current read done");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Reset, array fill, then the scenarios in order.
    initial begin
        rst = 1'b1;
        fill = '0;
        repeat (16) @(negedge mclk);
        rst = 1'b0;
        repeat (8) @(negedge mclk);
        for (int i = 0; i < 3; i++) begin
            put_word(12'h123 + 12'(i));
        end
        for (int i = -2; i < 3; i++) begin
            put_word(12'(i));
        end
        test_random();
        test_wrap();
        test_foreign();
        test_current();
        test_refused();
        complete_run();
    end
endmodule // serial_eeprom_read_engine_test

bind serial_eeprom_read_engine serial_eeprom_read_engine_monitor u_monitor (
    .mclk(mclk), .rst(rst), .scl_clk(scl_clk), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .standby(standby));
